// file: design/wwd_pkg.sv
// Package of constants and types for the windowed watchdog timer
// Summary of operation
// RULE_01: Unserviced overflow raises timeout, NMI, enters prewarning
// RULE_02: Prewarning lasts 0x30 counts, then system reset
// RULE_03: Service inside window: prewarning, no NMI
// RULE_04: Window spans zero to boundary byte times 256
// RULE_05: Valid service loads counter with reload times 256
// RULE_06: Counter clock is pclk divided by 2 or 128
// RULE_07: Reload byte supplies only the counter high byte
// RULE_08: Period follows prescale and reload formula, 16 bits
// RULE_09: Window boundary above reload shortens the period
// RULE_10: Software keeps boundary byte not below reload byte
// RULE_11: NMI delivered only while its enable is set
// RULE_12: Reset clears all; service cannot cancel prewarning
// RULE_13: Writable enable switches window checking on or off
package wwd_pkg;
  // Register word offsets (byte addresses)
  localparam logic [4:0] WWD_CTRL_OFS = 5'h00;
  localparam logic [4:0] WWD_RELOAD_OFS = 5'h04;
  localparam logic [4:0] WWD_WINDOW_OFS = 5'h08;
  localparam logic [4:0] WWD_SERVICE_OFS = 5'h0c;
  localparam logic [4:0] WWD_COUNT_OFS = 5'h10;
  // Control fields
  localparam int WWD_CTRL_PRESC_BIT = 0;
  localparam int WWD_CTRL_WINEN_BIT = 1;
  localparam int WWD_CTRL_NMIEN_BIT = 2;
  localparam int WWD_CTRL_RUN_BIT = 3;
  // Status and mask fields
  localparam int WWD_ST_TIMEOUT_BIT = 0;
  localparam int WWD_ST_INVALID_BIT = 1;
  localparam int WWD_ST_RESET_BIT = 2;
  // Service key written to the service register
  localparam logic [7:0] WWD_SERVICE_KEY = 8'ha5;
  // Prescaler ratios and prewarning length
  localparam int WWD_DIV_FAST = 2;
  localparam int WWD_DIV_SLOW = 128;
  localparam logic [7:0] WWD_PREWARN_COUNTS = 8'h30;
  localparam logic [15:0] WWD_COUNT_RESET = 16'h0000;
  // Watchdog phases
  typedef enum logic [2:0] {
    WWD_RUN = 3'b001,
    WWD_PREWARN = 3'b010,
    WWD_RESET = 3'b100
  } wwd_state_t;
endpackage : wwd_pkg

// file: design/wwd_prescaler.sv
// Counter tick prescaler, divide by 2 or by 128
`timescale 1ns/10ps
module wwd_prescaler
  import wwd_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clear_i,
  input wire logic slow_i,
  // Tick out
  output logic tick_o
);
  logic [6:0] div_q;

  // Free divider; clear restarts the phase after service
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
      div_q <= 7'h00;
    else
      div_q <= div_q + 7'h01;
  end

  // Tick on last phase of the chosen ratio
  assign tick_o = slow_i ? (div_q == 7'(WWD_DIV_SLOW - 1)) : div_q[0]; // RULE_06
endmodule : wwd_prescaler

// file: design/wwd_top.sv
// Windowed watchdog timer with Wishbone register access
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
module wwd_top
  import wwd_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Watchdog outputs
  output logic wdog_timeout_flag_o,
  output logic wdog_nmi_o,
  output logic wdog_system_reset_o,
  output logic irq_o
);
  logic ack_q;
  logic [31:0] rdata_q;
  logic [3:0] ctrl_q;
  logic [7:0] reload_high_byte_q;
  logic [7:0] refresh_window_byte_q;
  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic [15:0] count_q;
  logic [7:0] warn_q;
  wwd_state_t state_q;
  logic wdog_timeout_flag_q;
  logic tick;
  logic acc;
  logic wr;
  logic service;
  logic in_window;
  logic overflow;
  logic ev_timeout;
  logic ev_invalid;
  logic ev_reset;
  logic [2:0] events;

  localparam logic [4:0] WWD_STATUS_OFS = 5'h14;
  localparam logic [4:0] WWD_MASK_OFS = 5'h18;

  // Bus strobes; one access per request
  assign acc = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = acc && wb_we_i && wb_sel_i[0];
  assign service = wr && (wb_adr_i == 5'(WWD_SERVICE_OFS)) && (wb_dat_i[7:0] == WWD_SERVICE_KEY);

  // Window check uses boundary byte as high byte, low byte zero
  assign in_window = ctrl_q[WWD_CTRL_WINEN_BIT] &&
                     (count_q <= {refresh_window_byte_q, 8'h00}); // RULE_04 RULE_13
  assign overflow = tick && (count_q == 16'hffff) && (state_q == WWD_RUN);
  assign ev_timeout = overflow; // RULE_01
  assign ev_invalid = service && in_window && (state_q == WWD_RUN); // RULE_03
  assign ev_reset = (state_q == WWD_PREWARN) && tick && (warn_q == WWD_PREWARN_COUNTS - 8'h01);
  assign events = {ev_reset, ev_invalid, ev_timeout};

  // Prescaler restarts on valid service so periods start clean
  wwd_prescaler u_presc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(service && !in_window && state_q == WWD_RUN),
    .slow_i(ctrl_q[WWD_CTRL_PRESC_BIT]),
    .tick_o(tick)
  );

  // Wishbone acknowledge, one cycle after request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
  end
  assign wb_ack_o = ack_q;

  // Read data, unmapped reads as zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_q <= 32'h0;
    else if (acc)
      unique case (wb_adr_i)
        5'(WWD_CTRL_OFS): rdata_q <= {28'h0, ctrl_q};
        5'(WWD_RELOAD_OFS): rdata_q <= {24'h0, reload_high_byte_q};
        5'(WWD_WINDOW_OFS): rdata_q <= {24'h0, refresh_window_byte_q};
        5'(WWD_COUNT_OFS): rdata_q <= {16'h0, count_q};
        WWD_STATUS_OFS: rdata_q <= {29'h0, status_q};
        WWD_MASK_OFS: rdata_q <= {29'h0, mask_q};
        default: rdata_q <= 32'h0;
      endcase
  end
  assign wb_dat_o = rdata_q;

  // Configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= 4'h0;
      reload_high_byte_q <= 8'h00;
      refresh_window_byte_q <= 8'h00;
      mask_q <= 3'h0;
    end
    else if (wr)
    begin
      if (wb_adr_i == 5'(WWD_CTRL_OFS))
        ctrl_q <= wb_dat_i[3:0]; // RULE_06 RULE_13
      if (wb_adr_i == 5'(WWD_RELOAD_OFS))
        reload_high_byte_q <= wb_dat_i[7:0]; // RULE_07
      if (wb_adr_i == 5'(WWD_WINDOW_OFS))
        refresh_window_byte_q <= wb_dat_i[7:0];
      if (wb_adr_i == WWD_MASK_OFS)
        mask_q <= wb_dat_i[2:0];
    end
  end

  // Sticky status, write one to clear; a new event wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status_q <= 3'h0;
    else if (wr && wb_adr_i == WWD_STATUS_OFS)
      status_q <= (status_q & ~wb_dat_i[2:0]) | events;
    else
      status_q <= status_q | events;
  end
  assign irq_o = |(status_q & mask_q);

  // Watchdog counter; valid service reloads high byte
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_q <= WWD_COUNT_RESET; // RULE_12
    else if (state_q == WWD_RUN && service && !in_window)
      count_q <= {reload_high_byte_q, 8'h00}; // RULE_05 RULE_08 RULE_09
    else if (tick && ctrl_q[WWD_CTRL_RUN_BIT] && state_q == WWD_RUN)
      count_q <= count_q + 16'h0001; // RULE_08
  end

  // Phase machine; service in prewarning is ignored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= WWD_RUN; // RULE_12
      warn_q <= 8'h00;
    end
    else
      unique case (state_q)
        WWD_RUN:
        begin
          warn_q <= 8'h00;
          if (ctrl_q[WWD_CTRL_RUN_BIT] && (ev_timeout || ev_invalid))
            state_q <= WWD_PREWARN; // RULE_01 RULE_03
        end
        WWD_PREWARN:
        begin
          if (tick)
            warn_q <= warn_q + 8'h01;
          if (ev_reset)
            state_q <= WWD_RESET; // RULE_02 RULE_12
        end
        WWD_RESET:
          state_q <= WWD_RESET;
        default:
          state_q <= WWD_RUN;
      endcase
  end

  // Timeout flag only on overflow, not on invalid service
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wdog_timeout_flag_q <= 1'b0;
    else if (ev_timeout && ctrl_q[WWD_CTRL_RUN_BIT])
      wdog_timeout_flag_q <= 1'b1; // RULE_01
  end
  assign wdog_timeout_flag_o = wdog_timeout_flag_q;
  // NMI gated by its own enable
  assign wdog_nmi_o = wdog_timeout_flag_q && ctrl_q[WWD_CTRL_NMIEN_BIT]; // RULE_11
  // Held until an external system reset clears it
  assign wdog_system_reset_o = (state_q == WWD_RESET); // RULE_02

  // Helper: cycles spent in prewarning
  logic [15:0] pw_cyc_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_q != WWD_PREWARN)
      pw_cyc_q <= 16'h0;
    else
      pw_cyc_q <= pw_cyc_q + 16'h0001;
  end

  sequence s_enter_warn;
    state_q == WWD_RUN ##1 state_q == WWD_PREWARN;
  endsequence

  a_reset_after_warn: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
    (state_q == WWD_PREWARN) |-> (pw_cyc_q <= 16'd6144))
    else $error("prewarning too long");
  a_no_early_reset: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
    $rose(wdog_system_reset_o) |-> ($past(warn_q) == 8'h2f))
    else $error("reset before 0x30 counts");
  a_invalid_no_nmi: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
    (ev_invalid && !wdog_timeout_flag_q && ctrl_q[WWD_CTRL_RUN_BIT]) |=> !wdog_timeout_flag_q)
    else $error("invalid service raised timeout");
  a_timeout_enters: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
    (ev_timeout && ctrl_q[WWD_CTRL_RUN_BIT]) |=> (wdog_timeout_flag_q && state_q == WWD_PREWARN))
    else $error("overflow did not enter prewarning");
  a_reload_value: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
    (state_q == WWD_RUN && service && !in_window) |=> (count_q == {$past(reload_high_byte_q), 8'h00}))
    else $error("bad reload");
  a_window_blocks: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
    (service && state_q == WWD_RUN && ctrl_q[1] && count_q <= {refresh_window_byte_q, 8'h00})
    |=> state_q == WWD_PREWARN || !ctrl_q[WWD_CTRL_RUN_BIT])
    else $error("window service accepted");
  a_nmi_gate: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
    wdog_nmi_o |-> (wdog_timeout_flag_o && ctrl_q[WWD_CTRL_NMIEN_BIT]))
    else $error("nmi without enable");
  a_warn_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
    s_enter_warn |=> (state_q != WWD_RUN) [*8])
    else $error("prewarning cancelled");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  // One prewarning tick that is not the last one
  sequence s_warn_tick;
    state_q == WWD_PREWARN && tick && !ev_reset;
  endsequence

  // The last prewarning tick
  sequence s_last_tick;
    state_q == WWD_PREWARN && tick && (warn_q == WWD_PREWARN_COUNTS - 8'h01);
  endsequence

  // Every prewarning tick before the last advances the prewarning count
  a_warn_counts: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
    s_warn_tick |=> (warn_q == $past(warn_q) + 8'h01))
    else $error("prewarning tick lost");

  // The last tick leads straight into system reset
  a_last_tick_reset: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
    s_last_tick |=> (wdog_system_reset_o && status_q[WWD_ST_RESET_BIT]))
    else $error("no reset after last prewarning tick");

  // System reset stays until an external reset
  a_reset_holds: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
    wdog_system_reset_o |=> wdog_system_reset_o)
    else $error("system reset dropped");

  // Timeout flag is sticky until reset
  a_flag_holds: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
    wdog_timeout_flag_o |=> wdog_timeout_flag_o)
    else $error("timeout flag dropped");

  // Timeout only ever rises from a full counter
  a_flag_from_full: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
    $rose(wdog_timeout_flag_o) |-> ($past(count_q) == 16'hffff))
    else $error("timeout without overflow");

  // Overflow is recorded in the status register
  a_timeout_status: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
    ev_timeout |=> status_q[WWD_ST_TIMEOUT_BIT])
    else $error("timeout not recorded");

  // Invalid service is recorded in the status register
  a_invalid_status: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
    ev_invalid |=> status_q[WWD_ST_INVALID_BIT])
    else $error("invalid service not recorded");

  // With checking off any keyed service in the run phase reloads
  a_window_off: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
    (service && state_q == WWD_RUN && !ctrl_q[WWD_CTRL_WINEN_BIT])
    |=> (count_q == {$past(reload_high_byte_q), 8'h00}))
    else $error("service refused with window off");

  // Counter steps by one per tick while running
  a_count_steps: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
    (tick && ctrl_q[WWD_CTRL_RUN_BIT] && state_q == WWD_RUN && !service && count_q != 16'hffff)
    |=> (count_q == $past(count_q) + 16'h0001))
    else $error("counter step wrong");

  // Counter holds while stopped and unserviced
  a_count_halts: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
    (!ctrl_q[WWD_CTRL_RUN_BIT] && !service) |=> $stable(count_q))
    else $error("counter moved while stopped");

  // Counter frozen once prewarning has begun
  a_warn_frozen: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
    (state_q != WWD_RUN) |=> $stable(count_q))
    else $error("counter moved in prewarning");

  // NMI silent while its enable is clear
  a_nmi_off: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
    !ctrl_q[WWD_CTRL_NMIEN_BIT] |-> !wdog_nmi_o)
    else $error("nmi while disabled");

  // NMI follows an enabled timeout at once
  a_nmi_follows: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
    (wdog_timeout_flag_o && ctrl_q[WWD_CTRL_NMIEN_BIT]) |-> wdog_nmi_o)
    else $error("enabled nmi missing");

  // Every request is answered on the next edge
  a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged");

  // No answer without a request
  a_no_idle_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");

  // Unmapped space reads zero
  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (acc && !wb_we_i && wb_adr_i == 5'h1c) |=> (wb_dat_o == 32'h0))
    else $error("unmapped read not zero");
endmodule : wwd_top

// file: tb/wwd_top_test.sv
// Self-checking bench for the windowed watchdog timer
`timescale 1ns/10ps
module wwd_top_test
  import wwd_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, tmo, nmi, srst, irq_o;
  logic [31:0] rd;
  int bad_count = 0;
  int n_compared = 0;
  int n;
  // Free-running 25 MHz clock
  always #20 clk_i = ~clk_i;
  wwd_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wdog_timeout_flag_o(tmo), .wdog_nmi_o(nmi),
    .wdog_system_reset_o(srst), .irq_o(irq_o));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  // Cycle counts carry a few edges of bus and sampling latency
  task automatic near(input int got, input int exp);
    chk(((got > exp - 5) && (got < exp + 5)) ? exp : got, exp);
  endtask : near
  // One classic Wishbone cycle; ack is awaited, never assumed
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    if (k >= 20)
      chk(32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  // Count edges until timeout flag (0) or system reset (1) rises
  task automatic wait_hi(input int which, output int cnt);
    cnt = 0;
    while ((which ? srst : tmo) !== 1'b1 && cnt < 40000)
    begin
      @(posedge clk_i);
      cnt++;
    end
  endtask : wait_hi
  // Synchronous reset held for ten cycles
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : do_reset
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // Watchdog on the whole run, well beyond the slow-prescaler case
  initial
  begin
    #(40 * 60000);
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    do_reset();
    // Reset state and unmapped space
    wb(1'b0, WWD_CTRL_OFS, 0); chk(rd, 32'h0);
    wb(1'b0, WWD_COUNT_OFS, 0); chk(rd, 32'h0);
    wb(1'b0, 5'h1c, 0); chk(rd, 32'h0);
    chk({tmo, nmi, srst, irq_o}, 4'h0);
    $display("test reset done");
    // Fast prescaler, window off with a high boundary byte, NMI on
    wb(1'b1, WWD_RELOAD_OFS, 32'hff);
    wb(1'b1, WWD_WINDOW_OFS, 32'hff);
    wb(1'b1, 5'h18, 32'h1);
    wb(1'b1, WWD_CTRL_OFS, 32'hc);
    wb(1'b1, WWD_SERVICE_OFS, 32'ha5);
    wait_hi(0, n); near(n, 2 * 256);
    chk({nmi, irq_o, srst}, 3'b110);
    wb(1'b1, WWD_SERVICE_OFS, 32'ha5);
    wait_hi(1, n); near(n, 2 * 32'h30 - 4);
    wb(1'b0, 5'h14, 0); chk(rd, 32'h5);
    wb(1'b1, 5'h14, 32'h5);
    wb(1'b0, 5'h14, 0); chk(rd, 32'h0);
    chk({30'h0, irq_o, srst}, 32'h1);
    $display("test overflow done");
    // Window on: a service at count one is refused
    do_reset();
    wb(1'b1, WWD_RELOAD_OFS, 32'h80);
    wb(1'b1, WWD_WINDOW_OFS, 32'h81);
    wb(1'b1, WWD_CTRL_OFS, 32'he);
    wb(1'b1, WWD_SERVICE_OFS, 32'ha5);
    wait_hi(1, n); near(n, 2 * 32'h30);
    chk({tmo, nmi}, 2'b00);
    wb(1'b0, 5'h14, 0); chk(rd, 32'h6);
    $display("test window done");
    // Slow prescaler with NMI disabled
    do_reset();
    wb(1'b1, WWD_RELOAD_OFS, 32'hff);
    wb(1'b1, WWD_CTRL_OFS, 32'h9);
    wb(1'b1, WWD_SERVICE_OFS, 32'ha5);
    wb(1'b0, WWD_COUNT_OFS, 0); chk(rd[15:8], 8'hff);
    wait_hi(0, n); near(n, 128 * 256 - 4);
    chk({tmo, nmi}, 2'b10);
    $display("test slow done");
    tally_and_finish();
  end
endmodule : wwd_top_test
